// ### inc/wake_pkg.sv
// Constants, carriers and state codes for the wake frame detector
package wake_pkg;
	// Register offsets
	localparam logic [15:0] ADDR_BASIC_CONTROL = 16'h0000;
	localparam logic [15:0] ADDR_INT_ENABLE = 16'h0012;
	localparam logic [15:0] ADDR_INT_STATUS = 16'h0013;
	localparam logic [15:0] ADDR_WAKE_CONTROL = 16'h4000;
	localparam logic [15:0] ADDR_WAKE_IRQ_CFG = 16'h4003;
	localparam logic [15:0] ADDR_NODE_WORD0 = 16'h4004;
	localparam logic [15:0] ADDR_NODE_WORD1 = 16'h4005;
	localparam logic [15:0] ADDR_NODE_WORD2 = 16'h4006;
	// Field positions
	localparam int BC_SOFT_RESET_BIT = 15;
	localparam int BC_FLOAT_BIT = 10;
	localparam int IE_WAKE_BIT = 6;
	localparam int IS_WAKE_BIT = 6;
	localparam int WC_ENABLE_BIT = 2;
	localparam int WIC_PULSE_BIT = 7;
	localparam int WIC_WIDTH_LSB = 8;
	// Reset values
	localparam logic [15:0] RST_BASIC_CONTROL = 16'h0000;
	localparam logic [15:0] RST_INT_ENABLE = 16'h0000;
	localparam logic [15:0] RST_WAKE_CONTROL = 16'h0000;
	localparam logic [15:0] RST_WAKE_IRQ_CFG = 16'h0000;
	localparam logic [15:0] RST_NODE_WORD = 16'h0000;
	// Pattern shape
	localparam logic [7:0] SYNC_BYTE = 8'hFF;
	localparam logic [2:0] SYNC_LEN = 3'h6;
	localparam logic [2:0] ADDR_LAST_BYTE = 3'h5;
	localparam logic [3:0] ADDR_LAST_REPEAT = 4'hF;
	// Timing
	localparam int CLK_MHZ = 20;
	localparam int PULSE_NS_0 = 800;
	localparam int PULSE_NS_1 = 1600;
	localparam int PULSE_NS_2 = 3200;
	localparam int PULSE_NS_3 = 6400;
	localparam logic [7:0] PULSE_CYC_0 = 8'((PULSE_NS_0 * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] PULSE_CYC_1 = 8'((PULSE_NS_1 * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] PULSE_CYC_2 = 8'((PULSE_NS_2 * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] PULSE_CYC_3 = 8'((PULSE_NS_3 * CLK_MHZ + 999) / 1000);
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef struct packed {
		logic read;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic start;
		logic valid;
		logic [7:0] data;
		logic last;
		logic good;
	} rx_byte_t;

	typedef struct packed {
		logic dv;
		logic [3:0] data;
	} mii_rx_t;

	typedef struct packed {
		logic en;
		logic [3:0] data;
	} mii_tx_t;

	typedef enum logic [1:0] {
		HUNT = 2'b00,
		ADDR = 2'b01,
		FOUND = 2'b10
	} match_state_t;
endpackage

// ### src/wake_pattern_matcher.sv
// Byte-wise search for the wake pattern inside each received frame
`timescale 1ns/1ps
`default_nettype none
module wake_pattern_matcher (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic enable,
	input wire logic [47:0] node_address,
	input wire wake_pkg::rx_byte_t rx,
	output logic wake_event
);
	wake_pkg::match_state_t state;
	wake_pkg::match_state_t base_state;
	wake_pkg::match_state_t next_state;
	logic [2:0] sync_cnt;
	logic [2:0] base_sync;
	logic [2:0] next_sync;
	logic [2:0] byte_idx;
	logic [2:0] base_idx;
	logic [2:0] next_idx;
	logic [3:0] rep_cnt;
	logic [3:0] base_rep;
	logic [3:0] next_rep;
	logic [7:0] expected;
	logic is_sync;
	logic hit;
	logic frame_done;

	// Each frame starts its search from scratch
	assign base_state = rx.start ? wake_pkg::HUNT : state;
	assign base_sync = rx.start ? 3'h0 : sync_cnt;
	assign base_idx = rx.start ? 3'h0 : byte_idx;
	assign base_rep = rx.start ? 4'h0 : rep_cnt;
	assign expected = node_address[8 * (wake_pkg::ADDR_LAST_BYTE - base_idx) +: 8];
	assign is_sync = rx.data == wake_pkg::SYNC_BYTE;
	assign hit = rx.data == expected;
	// Only a good, complete frame may raise the event
	assign frame_done = rx.valid && rx.last && rx.good;

	always_comb begin
		next_state = base_state;
		next_sync = base_sync;
		next_idx = base_idx;
		next_rep = base_rep;
		if (rx.valid) begin
			unique case (base_state)
				wake_pkg::HUNT: begin
					if (base_sync == wake_pkg::SYNC_LEN && hit && !is_sync) begin
						next_state = wake_pkg::ADDR;
						next_idx = 3'h1;
						next_rep = 4'h0;
					end else if (is_sync) begin
						if (base_sync != wake_pkg::SYNC_LEN) begin
							next_sync = base_sync + 3'h1;
						end
					end else begin
						next_sync = 3'h0;
					end
				end
				wake_pkg::ADDR: begin
					if (hit) begin
						if (base_idx == wake_pkg::ADDR_LAST_BYTE) begin
							next_idx = 3'h0;
							if (base_rep == wake_pkg::ADDR_LAST_REPEAT) begin
								next_state = wake_pkg::FOUND;
							end else begin
								next_rep = base_rep + 4'h1;
							end
						end else begin
							next_idx = base_idx + 3'h1;
						end
					end else begin
						next_state = wake_pkg::HUNT;
						next_sync = is_sync ? 3'h1 : 3'h0;
						next_idx = 3'h0;
						next_rep = 4'h0;
					end
				end
				wake_pkg::FOUND: begin
					next_state = wake_pkg::FOUND;
				end
				default: begin
					next_state = wake_pkg::HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= wake_pkg::HUNT;
			sync_cnt <= 3'h0;
			byte_idx <= 3'h0;
			rep_cnt <= 4'h0;
			wake_event <= 1'b0;
		end else if (clear || !enable) begin
			state <= wake_pkg::HUNT;
			sync_cnt <= 3'h0;
			byte_idx <= 3'h0;
			rep_cnt <= 4'h0;
			wake_event <= 1'b0;
		end else begin
			state <= next_state;
			sync_cnt <= next_sync;
			byte_idx <= next_idx;
			rep_cnt <= next_rep;
			wake_event <= frame_done && next_state == wake_pkg::FOUND;
		end
	end
endmodule
`default_nettype wire

// ### src/wake_frame_detector.sv
// Wake frame detector with its registers, interrupts, strap and mac_port_float
//
// Summary of operation
// - While enabled, every received frame is scanned for the wake pattern.
// - Node address must repeat sixteen times back to back.
// - Six bytes of 0xFF must precede the address run, anywhere in frame.
// - Only a valid Ethernet frame turns a match into a wake event.
// - Node address lives in three registers from 0x4004 on.
// - Bit 2 of 0x4000 turns wake detection on or off.
// - Strap high at reset makes status light 0 the wake interrupt.
// - Bit 7 of 0x4003 picks level (0) or pulse (1), both active low.
// - Bits 9:8 of 0x4003 pick the pulse width.
// - Bit 6 of 0x12 ANDs the wake event onto the general interrupt.
// - Reading 0x13 clears a wake-caused general interrupt (in level mode only once the level is gone); bit 6 shows it.
// - Bit 10 of 0x0 floats MAC outputs and ignores MAC inputs.
// - Straps latch at hardware reset release, not at software reset.
`timescale 1ns/1ps
`default_nettype none
module wake_frame_detector (
	input wire logic sys_clk,
	input wire logic rst,
	input wire wake_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire wake_pkg::rx_byte_t rx_stream,
	input wire wake_pkg::mii_rx_t phy_rx,
	output wake_pkg::mii_rx_t mac_rx,
	output logic mac_rx_oe,
	input wire wake_pkg::mii_tx_t mac_tx_pins,
	output wake_pkg::mii_tx_t phy_tx,
	input wire logic strap_wake_select,
	input wire logic link_light,
	input wire logic other_irq_n,
	output logic status_light_0,
	output logic general_irq_n
);
	logic [15:0] basic_control;
	logic [15:0] interrupt_enable;
	logic [15:0] wake_control;
	logic [15:0] wake_interrupt_config;
	logic [15:0] node_address_word0;
	logic [15:0] node_address_word1;
	logic [15:0] node_address_word2;
	logic wake_status;
	logic wake_level;
	logic [7:0] pulse_cnt;
	logic strap_meta;
	logic strap_sync;
	logic [1:0] strap_cnt;
	logic wake_on_light;
	wake_pkg::mii_tx_t tx_meta;
	wake_pkg::mii_tx_t tx_sync;
	logic wake_event;

	// Address decode
	logic sel_bc;
	logic sel_ie;
	logic sel_is;
	logic sel_wc;
	logic sel_wic;
	logic sel_n0;
	logic sel_n1;
	logic sel_n2;
	logic wr_en;
	logic rd_en;
	logic soft_reset;
	logic status_read;
	assign wr_en = reg_req.write;
	assign rd_en = reg_req.read;
	assign sel_bc = reg_req.addr == wake_pkg::ADDR_BASIC_CONTROL;
	assign sel_ie = reg_req.addr == wake_pkg::ADDR_INT_ENABLE;
	assign sel_is = reg_req.addr == wake_pkg::ADDR_INT_STATUS;
	assign sel_wc = reg_req.addr == wake_pkg::ADDR_WAKE_CONTROL;
	assign sel_wic = reg_req.addr == wake_pkg::ADDR_WAKE_IRQ_CFG;
	assign sel_n0 = reg_req.addr == wake_pkg::ADDR_NODE_WORD0;
	assign sel_n1 = reg_req.addr == wake_pkg::ADDR_NODE_WORD1;
	assign sel_n2 = reg_req.addr == wake_pkg::ADDR_NODE_WORD2;
	assign soft_reset = wr_en && sel_bc && reg_req.wdata[wake_pkg::BC_SOFT_RESET_BIT];
	assign status_read = rd_en && sel_is;

	// Control fields
	logic wake_enabled;
	logic pulse_mode;
	logic [1:0] width_sel;
	logic merge_en;
	logic mac_port_float;
	logic [47:0] node_address;
	assign wake_enabled = wake_control[wake_pkg::WC_ENABLE_BIT];
	assign pulse_mode = wake_interrupt_config[wake_pkg::WIC_PULSE_BIT];
	assign width_sel = wake_interrupt_config[wake_pkg::WIC_WIDTH_LSB +: 2];
	assign merge_en = interrupt_enable[wake_pkg::IE_WAKE_BIT];
	assign mac_port_float = basic_control[wake_pkg::BC_FLOAT_BIT];
	// First byte on the wire is the high byte of word 0
	assign node_address = {node_address_word0, node_address_word1,
		node_address_word2};

	// Read data selection
	logic [15:0] status_view;
	logic [15:0] read_mux;
	logic [15:0] bc_view;
	assign status_view = 16'(wake_status) << wake_pkg::IS_WAKE_BIT;
	assign bc_view = basic_control & ~(16'h0001 << wake_pkg::BC_SOFT_RESET_BIT);
	assign read_mux = sel_bc ? bc_view :
		sel_ie ? interrupt_enable :
		sel_is ? status_view :
		sel_wc ? wake_control :
		sel_wic ? wake_interrupt_config :
		sel_n0 ? node_address_word0 :
		sel_n1 ? node_address_word1 :
		sel_n2 ? node_address_word2 : 16'h0000;

	// Register writes; a software reset restores every default
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			basic_control <= wake_pkg::RST_BASIC_CONTROL;
			interrupt_enable <= wake_pkg::RST_INT_ENABLE;
			wake_control <= wake_pkg::RST_WAKE_CONTROL;
			wake_interrupt_config <= wake_pkg::RST_WAKE_IRQ_CFG;
			node_address_word0 <= wake_pkg::RST_NODE_WORD;
			node_address_word1 <= wake_pkg::RST_NODE_WORD;
			node_address_word2 <= wake_pkg::RST_NODE_WORD;
		end else if (soft_reset) begin
			basic_control <= wake_pkg::RST_BASIC_CONTROL;
			interrupt_enable <= wake_pkg::RST_INT_ENABLE;
			wake_control <= wake_pkg::RST_WAKE_CONTROL;
			wake_interrupt_config <= wake_pkg::RST_WAKE_IRQ_CFG;
			node_address_word0 <= wake_pkg::RST_NODE_WORD;
			node_address_word1 <= wake_pkg::RST_NODE_WORD;
			node_address_word2 <= wake_pkg::RST_NODE_WORD;
		end else if (wr_en) begin
			if (sel_bc) begin
				basic_control <= reg_req.wdata;
			end
			if (sel_ie) begin
				interrupt_enable <= reg_req.wdata;
			end
			if (sel_wc) begin
				wake_control <= reg_req.wdata;
			end
			if (sel_wic) begin
				wake_interrupt_config <= reg_req.wdata;
			end
			if (sel_n0) begin
				node_address_word0 <= reg_req.wdata;
			end
			if (sel_n1) begin
				node_address_word1 <= reg_req.wdata;
			end
			if (sel_n2) begin
				node_address_word2 <= reg_req.wdata;
			end
		end
	end

	// Read answer, one cycle after the request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= rd_en;
			if (rd_en) begin
				reg_rdata <= read_mux;
			end
		end
	end

	// Pattern search over the receive byte stream
	wake_pattern_matcher matcher (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(soft_reset),
		.enable(wake_enabled),
		.node_address(node_address),
		.rx(rx_stream),
		.wake_event(wake_event)
	);

	// Pulse width choice
	logic [7:0] pulse_load;
	assign pulse_load = (width_sel == 2'h0) ? wake_pkg::PULSE_CYC_0 :
		(width_sel == 2'h1) ? wake_pkg::PULSE_CYC_1 :
		(width_sel == 2'h2) ? wake_pkg::PULSE_CYC_2 :
		wake_pkg::PULSE_CYC_3;

	// Level latch and pulse timer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_level <= 1'b0;
			pulse_cnt <= 8'h00;
		end else if (soft_reset) begin
			wake_level <= 1'b0;
			pulse_cnt <= 8'h00;
		end else begin
			// Level holds until detection is switched off or pulse mode is picked
			if (wake_event && !pulse_mode) begin
				wake_level <= 1'b1;
			end else if (!wake_enabled || pulse_mode) begin
				wake_level <= 1'b0;
			end
			if (wake_event && pulse_mode) begin
				pulse_cnt <= pulse_load;
			end else if (pulse_cnt != 8'h00) begin
				pulse_cnt <= pulse_cnt - 8'h01;
			end
		end
	end

	// Wake cause flag; new event beats the read clear
	logic status_set;
	logic status_clear;
	assign status_set = wake_event;
	// Level mode keeps the flag while the level stands
	assign status_clear = status_read && (pulse_mode || !wake_level);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_status <= 1'b0;
		end else if (soft_reset) begin
			wake_status <= 1'b0;
		end else if (status_set) begin
			wake_status <= 1'b1;
		end else if (status_clear) begin
			wake_status <= 1'b0;
		end
	end

	// Strap capture after hardware reset release only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
			strap_cnt <= 2'h0;
			wake_on_light <= 1'b0;
		end else begin
			strap_meta <= strap_wake_select;
			strap_sync <= strap_meta;
			if (strap_cnt != wake_pkg::STRAP_SETTLE + 2'h1) begin
				strap_cnt <= strap_cnt + 2'h1;
			end
			if (strap_cnt == wake_pkg::STRAP_SETTLE) begin
				wake_on_light <= strap_sync;
			end
		end
	end

	// Interrupt outputs
	logic wake_irq_n;
	logic next_light;
	logic next_general_n;
	assign wake_irq_n = pulse_mode ? (pulse_cnt == 8'h00) : !wake_level;
	assign next_light = wake_on_light ? wake_irq_n : link_light;
	assign next_general_n = other_irq_n && !(merge_en && wake_status);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_light_0 <= 1'b1;
			general_irq_n <= 1'b1;
		end else begin
			status_light_0 <= next_light;
			general_irq_n <= next_general_n;
		end
	end

	// MAC side pins; mac_port_float floats outputs and ignores inputs
	assign mac_rx_oe = !mac_port_float;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_meta <= '0;
			tx_sync <= '0;
			phy_tx <= '0;
			mac_rx <= '0;
		end else begin
			tx_meta <= mac_tx_pins;
			tx_sync <= tx_meta;
			phy_tx <= mac_port_float ? '0 : tx_sync;
			mac_rx <= mac_port_float ? '0 : phy_rx;
		end
	end
endmodule
`default_nettype wire

// ### bench/mac_model.sv
// Behavioural MAC that feeds transmit nibbles and watches receive nibbles
`timescale 1ns/1ps
`default_nettype none
module mac_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire wake_pkg::mii_rx_t mac_rx,
	input wire logic mac_rx_oe,
	output wake_pkg::mii_tx_t mac_tx
);
	logic [3:0] cnt = 4'h0;
	// Host keeps the PHY powered: no power-down request ever issued
	// Received nibbles are folded in only while the PHY drives them
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			cnt <= 4'h0;
		else
			cnt <= cnt + (mac_rx_oe ? mac_rx.data : 4'h5) + 4'h1;
	end
	assign mac_tx = '{|cnt, cnt};
endmodule
`default_nettype wire

// ### bench/wake_frame_detector_properties.sv
// Port-level checks for the wake frame detector
`timescale 1ns/1ps
`default_nettype none
module wake_frame_detector_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire wake_pkg::reg_req_t reg_req,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire wake_pkg::rx_byte_t rx_stream,
	input wire wake_pkg::mii_rx_t phy_rx,
	input wire wake_pkg::mii_rx_t mac_rx,
	input wire logic mac_rx_oe,
	input wire wake_pkg::mii_tx_t mac_tx_pins,
	input wire wake_pkg::mii_tx_t phy_tx,
	input wire logic strap_wake_select,
	input wire logic link_light,
	input wire logic other_irq_n,
	input wire logic status_light_0,
	input wire logic general_irq_n
);
	logic strap_q;
	always_ff @(posedge sys_clk) begin
		if (rst)
			strap_q <= strap_wake_select;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence word0_wr_rd;
		reg_req.write && reg_req.addr == wake_pkg::ADDR_NODE_WORD0
		##1 !reg_req.write ##1 reg_req.read && !reg_req.write
		&& reg_req.addr == wake_pkg::ADDR_NODE_WORD0;
	endsequence
	a_read_answer: assert property (
		reg_rvalid == $past(reg_req.read)) else $error("read answer late");
	a_node_store: assert property (
		word0_wr_rd |=> reg_rdata == $past(reg_req.wdata, 3))
		else $error("node word not stored");
	a_status_bits: assert property (
		reg_req.read && reg_req.addr == wake_pkg::ADDR_INT_STATUS
		|=> reg_rdata[15:7] == 9'h000 && reg_rdata[5:0] == 6'h00)
		else $error("status shows stray bits");
	a_float_zero: assert property (
		!mac_rx_oe [*2] |-> mac_rx == '0 && phy_tx == '0)
		else $error("isolated outputs not quiet");
	a_rx_copy: assert property (
		mac_rx_oe && $past(mac_rx_oe) |-> mac_rx == $past(phy_rx))
		else $error("receive copy wrong");
	a_tx_copy: assert property (
		mac_rx_oe [*4] |-> phy_tx == $past(mac_tx_pins, 3))
		else $error("transmit copy wrong");
	a_other_merge: assert property (
		!other_irq_n |=> !general_irq_n) else $error("general irq missed");
	a_gen_cause: assert property (
		$fell(general_irq_n) && $past(other_irq_n) |->
		$past(rx_stream.valid && rx_stream.last && rx_stream.good, 3))
		else $error("general irq without frame");
	a_light_link: assert property (
		!strap_q |-> status_light_0 == $past(link_light))
		else $error("light not link");
	a_light_cause: assert property (
		strap_q && $fell(status_light_0) |->
		$past(rx_stream.valid && rx_stream.last && rx_stream.good, 3))
		else $error("wake irq without frame");
endmodule
bind wake_frame_detector wake_frame_detector_checker chk (
	.sys_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .rx_stream,
	.phy_rx, .mac_rx, .mac_rx_oe, .mac_tx_pins, .phy_tx,
	.strap_wake_select, .link_light, .other_irq_n, .status_light_0,
	.general_irq_n
);
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the wake frame detector
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [47:0] NA = 48'h0211_2233_4455;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	wake_pkg::reg_req_t reg_req = '0;
	wake_pkg::rx_byte_t rx_stream = '0;
	wake_pkg::mii_rx_t phy_rx = '0;
	wake_pkg::mii_tx_t mac_tx_pins;
	logic strap_wake_select = 1'b0;
	logic link_light = 1'b1;
	logic other_irq_n = 1'b1;
	logic [15:0] reg_rdata;
	logic reg_rvalid, mac_rx_oe, status_light_0, general_irq_n;
	wake_pkg::mii_rx_t mac_rx;
	wake_pkg::mii_tx_t phy_tx;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	wake_frame_detector dut (
		.sys_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .rx_stream,
		.phy_rx, .mac_rx, .mac_rx_oe, .mac_tx_pins, .phy_tx,
		.strap_wake_select, .link_light, .other_irq_n, .status_light_0,
		.general_irq_n
	);
	mac_model mac (.sys_clk, .rst, .mac_rx, .mac_rx_oe, .mac_tx(mac_tx_pins));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		phy_rx <= rst ? 5'h00 : 5'(cyc);
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end
	task test_done;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task check(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_req <= '{1'b0, 1'b1, a, d};
		@(posedge sys_clk);
		reg_req <= '0;
	endtask
	task rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_req <= '{1'b1, 1'b0, a, 16'h0000};
		@(posedge sys_clk);
		reg_req <= '0;
		#1;
		d = reg_rdata;
		check("rvalid", 16'(reg_rvalid), 16'h0001);
	endtask
	task send(input int f, input int r, input bit g);
		logic [7:0] b;
		int i, n;
		n = f + r * 6 + 2;
		for (i = 0; i < n; i++) begin
			b = (i == 0 || i == n - 1) ? 8'h00 : (i <= f) ? 8'hFF :
				NA[47 - 8 * ((i - f - 1) % 6) -: 8];
			@(posedge sys_clk);
			rx_stream <= '{i == 0, 1'b1, b, i == n - 1, g};
		end
		@(posedge sys_clk);
		rx_stream <= '0;
	endtask
	task meas(output logic [15:0] w);
		int k;
		w = 16'h0000;
		for (k = 0; k < 300; k++) begin
			tick(1);
			if (status_light_0 === 1'b0)
				w++;
		end
	endtask
	task cfg(input logic [15:0] m);
		int i;
		for (i = 0; i < 3; i++)
			wr(wake_pkg::ADDR_NODE_WORD0 + 16'(i), NA[47 - 16 * i -: 16]);
		wr(wake_pkg::ADDR_WAKE_IRQ_CFG, m);
		wr(wake_pkg::ADDR_WAKE_CONTROL, 16'h0004);
	endtask
	task hw_reset;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		tick(4);
	endtask
	task t_regs;
		logic [15:0] d;
		logic [15:0] ba [3] = '{16'h0000, 16'h0012, 16'h0013};
		int k;
		for (k = 0; k < 10; k++) begin
			rd((k < 3) ? ba[k] : 16'h4000 + 16'(k - 3), d);
			check("reset value", d, 16'h0000);
		end
		wr(wake_pkg::ADDR_NODE_WORD0, 16'hA5C3);
		rd(wake_pkg::ADDR_NODE_WORD0, d);
		check("node word", d, 16'hA5C3);
		wr(16'h4001, 16'hFFFF);
		rd(16'h4001, d);
		check("unmapped", d, 16'h0000);
		wr(wake_pkg::ADDR_INT_STATUS, 16'hFFFF);
		rd(wake_pkg::ADDR_INT_STATUS, d);
		check("status write", d, 16'h0000);
	endtask
	task t_iso;
		wr(wake_pkg::ADDR_BASIC_CONTROL, 16'h0400);
		tick(3);
		check("oe", 16'(mac_rx_oe), 16'h0000);
		check("mac_rx", 16'(mac_rx), 16'h0000);
		check("phy_tx", 16'(phy_tx), 16'h0000);
		wr(wake_pkg::ADDR_BASIC_CONTROL, 16'h0000);
		tick(5);
		check("oe back", 16'(mac_rx_oe), 16'h0001);
	endtask
	task t_strap;
		logic [15:0] w;
		@(posedge sys_clk);
		link_light <= 1'b0;
		tick(2);
		check("link light", 16'(status_light_0), 16'h0000);
		@(posedge sys_clk);
		link_light <= 1'b1;
		strap_wake_select <= 1'b1;
		wr(wake_pkg::ADDR_BASIC_CONTROL, 16'h8000);
		cfg(16'h0080);
		send(6, 16, 1'b1);
		meas(w);
		check("no relatch", w, 16'h0000);
		rd(wake_pkg::ADDR_INT_STATUS, w);
		check("event seen", w, 16'h0040);
	endtask
	task t_wake;
		logic [15:0] w;
		logic [7:0] pw [4];
		int s;
		pw = '{wake_pkg::PULSE_CYC_0, wake_pkg::PULSE_CYC_1,
			wake_pkg::PULSE_CYC_2, wake_pkg::PULSE_CYC_3};
		for (s = 0; s < 4; s++) begin
			cfg({6'h00, 2'(s), 8'h80});
			send(6 + s, 16, 1'b1);
			meas(w);
			check("pulse width", w, 16'(pw[s]));
		end
	endtask
	task t_bad;
		logic [15:0] w;
		int f [5] = '{5, 6, 6, 6, 0};
		int r [5] = '{16, 15, 16, 8, 8};
		bit g [5] = '{1, 1, 0, 1, 1};
		int k;
		cfg(16'h0080);
		for (k = 0; k < 5; k++) begin
			send(f[k], r[k], g[k]);
			meas(w);
			check("bad frame", w, 16'h0000);
		end
		wr(wake_pkg::ADDR_WAKE_CONTROL, 16'h0000);
		send(6, 16, 1'b1);
		meas(w);
		check("disabled", w, 16'h0000);
	endtask
	task t_gen;
		logic [15:0] d;
		rd(wake_pkg::ADDR_INT_STATUS, d);
		check("stale cause", d, 16'h0040);
		cfg(16'h0000);
		wr(wake_pkg::ADDR_INT_ENABLE, 16'h0040);
		send(6, 16, 1'b1);
		tick(5);
		check("general", 16'(general_irq_n), 16'h0000);
		rd(wake_pkg::ADDR_INT_STATUS, d);
		check("cause", d, 16'h0040);
		tick(3);
		check("level kept", 16'(general_irq_n), 16'h0000);
		check("level light", 16'(status_light_0), 16'h0000);
		wr(wake_pkg::ADDR_WAKE_CONTROL, 16'h0000);
		rd(wake_pkg::ADDR_INT_STATUS, d);
		tick(3);
		check("level gone", 16'(status_light_0), 16'h0001);
		check("read clear", 16'(general_irq_n), 16'h0001);
		cfg(16'h0080);
		send(6, 16, 1'b1);
		meas(d);
		check("held", 16'(general_irq_n), 16'h0000);
		rd(wake_pkg::ADDR_INT_STATUS, d);
		check("pulse cause", d, 16'h0040);
		tick(3);
		check("cleared", 16'(general_irq_n), 16'h0001);
		@(posedge sys_clk);
		other_irq_n <= 1'b0;
		tick(2);
		check("merge", 16'(general_irq_n), 16'h0000);
		@(posedge sys_clk);
		other_irq_n <= 1'b1;
	endtask
	initial begin
		hw_reset();
		t_regs();
		t_iso();
		t_strap();
		hw_reset();
		t_wake();
		t_bad();
		t_gen();
		test_done();
	end
endmodule
`default_nettype wire
